// ### rtl/pd_wake_pkg.sv
// Constants and types shared by the power-down wake-up controller.
package pd_wake_pkg;
	localparam int PIN_COUNT = 8;
	localparam int SEL_W = 2;
	localparam int LOW_PINS = 4;
	// Register byte addresses on APB.
	localparam logic [15:0] ADDR_EDGE_SELECT = 16'hf1c0;
	localparam logic [15:0] ADDR_SYS_CONFIG = 16'hf1c4;
	localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hf1c8;
	localparam logic [15:0] ADDR_IRQ_FLAGS = 16'hf1cc;
	localparam logic [15:0] ADDR_WAKE_DELAY = 16'hf1d0;
	localparam logic [15:0] ADDR_CONTROL = 16'hf1d4;
	localparam logic [15:0] ADDR_STATUS = 16'hf1d8;
	localparam logic [15:0] ADDR_EVT_STATUS = 16'hf1dc;
	localparam logic [15:0] ADDR_EVT_CLEAR = 16'hf1e0;
	localparam logic [15:0] ADDR_EVT_ENABLE = 16'hf1e4;
	localparam logic [15:0] EDGE_SELECT_RESET = 16'h0000;
	localparam int PWD_CFG_BIT = 5;
	localparam int CTRL_POWER_DOWN_INSTRUCTION_BIT = 0;
	localparam int CTRL_RDY_EN_BIT = 1;
	localparam int CTRL_RDY_SEEN_BIT = 2;
	localparam int CTRL_BUS_IDLE_BIT = 3;
	localparam logic [15:0] WAKE_DELAY_RESET = 16'h0010;
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_RISE = 2'h1;
	localparam logic [1:0] SEL_FALL = 2'h2;
	localparam logic [1:0] SEL_ANY = 2'h3;
	// Event bits: entered, woke by pin, woke by reset, entry refused.
	localparam int EVT_W = 4;
	localparam int EVT_ENTER = 0;
	localparam int EVT_PIN_WAKE = 1;
	localparam int EVT_RST_WAKE = 2;
	localparam int EVT_REFUSED = 3;
	typedef enum logic [2:0] {st_run, st_down, st_settle, st_resume, st_isr} pd_state_t;
endpackage

// ### rtl/fast_pin_cell.sv
// One fast interrupt pin: edge detection, entry permission and wake detection.
`timescale 1ns/1ps
`default_nettype none
module fast_pin_cell
	import pd_wake_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// Pin and configuration.
	input wire logic pin_i,
	input wire logic [1:0] sel_i,
	input wire logic latch_i,
	// Results.
	output logic edge_o,
	output logic idle_ok_o,
	output logic wake_o
);
	logic prev;
	logic entry_level;
	logic next_prev;
	logic next_entry_level;

	always_comb begin
		next_prev = pin_i;
		next_entry_level = latch_i ? pin_i : entry_level;
		unique case (sel_i)
			SEL_RISE: begin
				edge_o = pin_i & ~prev;
				idle_ok_o = ~pin_i;
				wake_o = pin_i;
			end
			SEL_FALL: begin
				edge_o = ~pin_i & prev;
				idle_ok_o = pin_i;
				wake_o = ~pin_i;
			end
			SEL_ANY: begin
				edge_o = pin_i ^ prev;
				idle_ok_o = 1'b1;
				wake_o = pin_i ^ entry_level;
			end
			default: begin
				edge_o = 1'b0;
				idle_ok_o = 1'b1;
				wake_o = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev <= 1'b0;
			entry_level <= 1'b0;
		end else begin
			prev <= next_prev;
			entry_level <= next_entry_level;
		end
	end
endmodule
`default_nettype wire

// ### rtl/pd_wake_ctrl.sv
// Interruptible power-down entry and wake-up controller with APB registers.
// Overview of operation
// - Interruptible power down is chosen when config bit 5 is set.
// - Entry only when every enabled fast pin sits at its inactive level.
// - Leave power down on external reset or a fast pin wake-up.
// - Each pin has a two-bit select; 00 disables it entirely.
// - Select 01: rising edge interrupt, enter while low, exit when high.
// - Select 10: falling edge interrupt, enter while high, exit when low.
// - Select 11: any edge, never blocks entry, exit on level change.
// - Outside power down pins are sampled; wake logic uses them as levels.
// - Pins 3..0 wake regardless of their interrupt enable bit.
// - A valid wake restarts oscillator and PLL and starts delay discharge.
// - Clocks stay gated until the delay expires and clears the hold flip-flop.
// - With the interrupt enabled, the service routine runs after wake-up.
// - With it disabled, execution continues and the request flag stays set.
// - The instruction after power down executes before the service routine.
// - A power-down instruction enters the mode and holds everything.
// - Pending bus actions finish first; no entry if ready never came.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pd_wake_ctrl
	import pd_wake_pkg::*;
#(
	parameter int PINS = PIN_COUNT,
	parameter int DELAY_W = 16
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [15:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// External pins.
	input wire logic [PINS-1:0] fast_irq_pin_i,
	input wire logic external_reset_input_n_i,
	// Clock and execution control.
	output logic osc_pll_en_o,
	output logic wake_delay_discharge_o,
	output logic clocks_gated_o,
	output logic exec_next_o,
	output logic isr_call_o,
	output logic irq_o
);
	pd_state_t state, next_state;
	logic [15:0] fast_irq_edge_select, next_edge_select;
	logic [15:0] system_config_reg, next_sys_config;
	logic [PINS-1:0] irq_enable_bit, next_irq_enable;
	logic [PINS-1:0] irq_request_flag, next_irq_flags;
	logic [DELAY_W-1:0] wake_delay, next_wake_delay;
	logic [DELAY_W-1:0] delay_cnt, next_delay_cnt;
	logic clock_hold_flipflop, next_hold;
	logic rdy_en, next_rdy_en;
	logic rdy_seen, next_rdy_seen;
	logic bus_idle, next_bus_idle;
	logic [EVT_W-1:0] evt_status, next_evt_status;
	logic [EVT_W-1:0] evt_enable, next_evt_enable;
	logic [PINS-1:0] woke_pins, next_woke_pins;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, next_irq;
	logic next_osc, next_dis, next_exec, next_isr;
	logic [PINS-1:0] pin_edge, pin_ok, pin_wake;
	logic [PINS-1:0] wake_qual;
	logic all_ok, power_down_instruction_req, latch;
	logic wr, rd;
	logic [EVT_W-1:0] evt_set;

	// Writes take effect on the edge at which the master sees pready high.
	assign wr = psel_i & penable_i & pwrite_i & pready_o;
	assign rd = psel_i & penable_i & ~pwrite_i;
	assign power_down_instruction_req = wr & (paddr_i == ADDR_CONTROL) & pwdata_i[CTRL_POWER_DOWN_INSTRUCTION_BIT];
	assign latch = (state == st_run);
	assign all_ok = &pin_ok;

	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_pin
			fast_pin_cell u_cell (
				.sys_clk_i(sys_clk_i),
				.arst_n_i(arst_n_i),
				.pin_i(fast_irq_pin_i[g]),
				.sel_i(fast_irq_edge_select[2*g+1 -: 2]),
				.latch_i(latch),
				.edge_o(pin_edge[g]),
				.idle_ok_o(pin_ok[g]),
				.wake_o(pin_wake[g])
			);
			// Pins 3..0 wake without their enable; higher pins need it.
			assign wake_qual[g] = pin_wake[g] & ((g < LOW_PINS) | irq_enable_bit[g]);
		end
	endgenerate

	// Power sequencing state machine.
	always_comb begin
		next_state = state;
		next_delay_cnt = delay_cnt;
		next_hold = clock_hold_flipflop;
		next_woke_pins = woke_pins;
		next_osc = osc_pll_en_o;
		next_dis = wake_delay_discharge_o;
		next_exec = 1'b0;
		next_isr = 1'b0;
		evt_set = '0;
		next_irq_flags = irq_request_flag;
		case (state)
			st_run: begin
				// Edges are sampled normally while running.
				next_irq_flags = irq_request_flag | pin_edge;
				// Bus status is the one left by the previous control write.
				if (power_down_instruction_req) begin
					if (system_config_reg[PWD_CFG_BIT] && all_ok && bus_idle
						&& (!rdy_en || rdy_seen)) begin
						next_state = st_down;
						next_hold = 1'b1;
						next_osc = 1'b0;
						evt_set[EVT_ENTER] = 1'b1;
					end else begin
						evt_set[EVT_REFUSED] = 1'b1;
					end
				end
			end
			st_down: begin
				// Levels, not edges, are watched while the clock is stopped.
				if (!external_reset_input_n_i) begin
					next_state = st_settle;
					next_osc = 1'b1;
					next_dis = 1'b1;
					next_delay_cnt = wake_delay;
					next_woke_pins = '0;
					evt_set[EVT_RST_WAKE] = 1'b1;
				end else if (|wake_qual) begin
					next_state = st_settle;
					next_osc = 1'b1;
					next_dis = 1'b1;
					next_delay_cnt = wake_delay;
					next_woke_pins = wake_qual;
					next_irq_flags = irq_request_flag | wake_qual;
					evt_set[EVT_PIN_WAKE] = 1'b1;
				end
			end
			st_settle: begin
				// The wait lasts one cycle longer than wake_delay, so zero still waits.
				if (delay_cnt == '0) begin
					next_hold = 1'b0;
					next_dis = 1'b0;
					next_state = st_resume;
				end else begin
					next_delay_cnt = delay_cnt - 1'b1;
				end
			end
			st_resume: begin
				next_exec = 1'b1;
				next_state = (|(woke_pins & irq_enable_bit)) ? st_isr : st_run;
			end
			st_isr: begin
				next_isr = 1'b1;
				next_irq_flags = irq_request_flag & ~(woke_pins & irq_enable_bit);
				next_state = st_run;
			end
			default: next_state = st_run;
		endcase
		// A pin edge in the same cycle as a software clear keeps its flag.
		if (wr && paddr_i == ADDR_IRQ_FLAGS) begin
			next_irq_flags = (next_irq_flags & pwdata_i[PINS-1:0]) | (pin_edge & {PINS{latch}});
		end
	end

	// Register file and APB answer.
	always_comb begin
		next_edge_select = fast_irq_edge_select;
		next_sys_config = system_config_reg;
		next_irq_enable = irq_enable_bit;
		next_wake_delay = wake_delay;
		next_rdy_en = rdy_en;
		next_rdy_seen = rdy_seen;
		next_bus_idle = bus_idle;
		next_evt_enable = evt_enable;
		next_evt_status = evt_status;
		next_prdata = prdata_o;
		// One wait state: pready rises on the first access edge, read data with it.
		next_pready = psel_i & penable_i & ~pready_o;
		next_pslverr = 1'b0;
		if (wr) begin
			case (paddr_i)
				ADDR_EDGE_SELECT: next_edge_select = pwdata_i[15:0];
				ADDR_SYS_CONFIG: next_sys_config = pwdata_i[15:0];
				ADDR_IRQ_ENABLE: next_irq_enable = pwdata_i[PINS-1:0];
				ADDR_WAKE_DELAY: next_wake_delay = pwdata_i[DELAY_W-1:0];
				ADDR_CONTROL: begin
					next_rdy_en = pwdata_i[CTRL_RDY_EN_BIT];
					next_rdy_seen = pwdata_i[CTRL_RDY_SEEN_BIT];
					next_bus_idle = pwdata_i[CTRL_BUS_IDLE_BIT];
				end
				ADDR_EVT_CLEAR: next_evt_status = evt_status & ~pwdata_i[EVT_W-1:0];
				ADDR_EVT_ENABLE: next_evt_enable = pwdata_i[EVT_W-1:0];
				ADDR_IRQ_FLAGS, ADDR_STATUS, ADDR_EVT_STATUS: ;
				default: next_pslverr = 1'b1;
			endcase
		end
		// An event in the same cycle as its clear keeps the bit set.
		next_evt_status = next_evt_status | evt_set;
		// Status reads give the state in [2:0], the hold flag in [3] and woken pins above.
		if (rd && !pready_o) begin
			next_prdata = '0;
			case (paddr_i)
				ADDR_EDGE_SELECT: next_prdata[15:0] = fast_irq_edge_select;
				ADDR_SYS_CONFIG: next_prdata[15:0] = system_config_reg;
				ADDR_IRQ_ENABLE: next_prdata[PINS-1:0] = irq_enable_bit;
				ADDR_IRQ_FLAGS: next_prdata[PINS-1:0] = irq_request_flag;
				ADDR_WAKE_DELAY: next_prdata[DELAY_W-1:0] = wake_delay;
				ADDR_CONTROL: next_prdata[3:0] = {bus_idle, rdy_seen, rdy_en, 1'b0};
				ADDR_STATUS: next_prdata[PINS+3:0] = {woke_pins, clock_hold_flipflop, state};
				ADDR_EVT_STATUS: next_prdata[EVT_W-1:0] = evt_status;
				ADDR_EVT_ENABLE: next_prdata[EVT_W-1:0] = evt_enable;
				ADDR_EVT_CLEAR: ;
				default: next_pslverr = 1'b1;
			endcase
		end else if (psel_i && penable_i && !pready_o) begin
			// Write errors are decoded on the wait edge so that pslverr stands with pready.
			case (paddr_i)
				ADDR_EDGE_SELECT, ADDR_SYS_CONFIG, ADDR_IRQ_ENABLE, ADDR_IRQ_FLAGS: ;
				ADDR_WAKE_DELAY, ADDR_CONTROL, ADDR_STATUS: ;
				ADDR_EVT_STATUS, ADDR_EVT_CLEAR, ADDR_EVT_ENABLE: ;
				default: next_pslverr = 1'b1;
			endcase
		end else if (psel_i && penable_i) begin
			next_pslverr = pslverr_o;
		end
		next_irq = |(next_evt_status & next_evt_enable);
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= st_run;
			delay_cnt <= '0;
			clock_hold_flipflop <= 1'b0;
			woke_pins <= '0;
			irq_request_flag <= '0;
			osc_pll_en_o <= 1'b1;
			wake_delay_discharge_o <= 1'b0;
			exec_next_o <= 1'b0;
			isr_call_o <= 1'b0;
			fast_irq_edge_select <= EDGE_SELECT_RESET;
			system_config_reg <= '0;
			irq_enable_bit <= '0;
			wake_delay <= WAKE_DELAY_RESET[DELAY_W-1:0];
			rdy_en <= 1'b0;
			rdy_seen <= 1'b0;
			bus_idle <= 1'b1;
			evt_status <= '0;
			evt_enable <= '0;
			prdata_o <= '0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			state <= next_state;
			delay_cnt <= next_delay_cnt;
			clock_hold_flipflop <= next_hold;
			woke_pins <= next_woke_pins;
			irq_request_flag <= next_irq_flags;
			osc_pll_en_o <= next_osc;
			wake_delay_discharge_o <= next_dis;
			exec_next_o <= next_exec;
			isr_call_o <= next_isr;
			fast_irq_edge_select <= next_edge_select;
			system_config_reg <= next_sys_config;
			irq_enable_bit <= next_irq_enable;
			wake_delay <= next_wake_delay;
			rdy_en <= next_rdy_en;
			rdy_seen <= next_rdy_seen;
			bus_idle <= next_bus_idle;
			evt_status <= next_evt_status;
			evt_enable <= next_evt_enable;
			prdata_o <= next_prdata;
			pready_o <= next_pready;
			pslverr_o <= next_pslverr;
			irq_o <= next_irq;
		end
	end

	// Held-clock output mirrors the hold flip-flop.
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clocks_gated_o <= 1'b0;
		end else begin
			clocks_gated_o <= next_hold;
		end
	end
endmodule
`default_nettype wire

// ### tb/pd_wake_asserts.sv
// Port assertions for the power-down controller.
`timescale 1ns/1ps
`default_nettype none
module pd_wake_asserts (
	// Watched ports.
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic external_reset_input_n_i,
	input wire logic osc_pll_en_o,
	input wire logic wake_delay_discharge_o,
	input wire logic clocks_gated_o,
	input wire logic exec_next_o,
	input wire logic isr_call_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	apb_ready_a: assert property (psel_i && penable_i |-> ##[0:2] pready_o)
		else $error("no ready");
	osc_off_a: assert property (!osc_pll_en_o |-> clocks_gated_o)
		else $error("osc off in run");
	rst_wake_a: assert property (!osc_pll_en_o && !external_reset_input_n_i
		|-> ##[1:4] osc_pll_en_o) else $error("reset did not wake");
	wake_osc_a: assert property ($rose(wake_delay_discharge_o) |-> osc_pll_en_o)
		else $error("discharge without osc");
	hold_gate_a: assert property (wake_delay_discharge_o |-> clocks_gated_o)
		else $error("clocks free in settle");
	gate_exec_a: assert property (clocks_gated_o |-> !exec_next_o && !isr_call_o)
		else $error("run while gated");
	release_exec_a: assert property ($fell(clocks_gated_o) |-> ##[0:1] exec_next_o)
		else $error("no run after release");
	isr_after_a: assert property (isr_call_o |-> $past(exec_next_o))
		else $error("isr too early");
endmodule
bind pd_wake_ctrl pd_wake_asserts chk (
	.sys_clk_i, .arst_n_i, .psel_i, .penable_i, .pready_o, .external_reset_input_n_i,
	.osc_pll_en_o, .wake_delay_discharge_o, .clocks_gated_o, .exec_next_o, .isr_call_o
);
`default_nettype wire

// ### tb/pd_pin_src.sv
// Far side: fast interrupt sources and the reset switch.
`timescale 1ns/1ps
`default_nettype none
module pd_pin_src #(
	parameter int HOLD = 10
) (
	// Requests and pins.
	input wire logic clk_i,
	input wire logic [7:0] want_i,
	input wire logic rst_req_i,
	output logic [7:0] pin_o = 8'h00,
	output logic rst_n_o = 1'h1
);
	int cnt = 0;
	// Each new level is held HOLD+1 cycles before another change is taken.
	always @(posedge clk_i) begin
		if (cnt != 0) begin
			cnt <= cnt - 1;
		end else if (pin_o != want_i || rst_n_o == rst_req_i) begin
			cnt <= HOLD;
			pin_o <= want_i;
			rst_n_o <= !rst_req_i;
		end
	end
endmodule
`default_nettype wire

// ### tb/interruptible_power_down_wakeup_tb.sv
// Scenario bench for the power-down controller.
`timescale 1ns/1ps
`default_nettype none
module interruptible_power_down_wakeup_tb
	import pd_wake_pkg::*;
;
	logic sys_clk_i = 1'h0, arst_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0;
	logic pwrite_i = 1'h0, rst_req = 1'h0;
	logic [15:0] paddr_i = 16'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [7:0] want = 8'h0;
	logic [31:0] prdata_o, rd;
	logic [7:0] fast_irq_pin_i;
	logic pready_o, pslverr_o, err, osc_pll_en_o, wake_delay_discharge_o, irq_o;
	logic clocks_gated_o, exec_next_o, isr_call_o, external_reset_input_n_i;
	int fail_count = 0, cmp_count = 0, cyc = 0;
	pd_wake_ctrl DUT (
		.sys_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .fast_irq_pin_i, .external_reset_input_n_i,
		.osc_pll_en_o, .wake_delay_discharge_o, .clocks_gated_o, .exec_next_o,
		.isr_call_o, .irq_o
	);
	pd_pin_src SRC (
		.clk_i(sys_clk_i), .want_i(want), .rst_req_i(rst_req),
		.pin_o(fast_irq_pin_i), .rst_n_o(external_reset_input_n_i)
	);
	always #2 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 8000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("cmp %0d bad %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'h1;
		do @(posedge sys_clk_i); while (pready_o !== 1'h1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask
	task automatic sleep_wake(input string n, input logic [15:0] sel,
		input logic [7:0] en, idle, wake, input int pin, input logic isr);
		int dis_n = 0;
		want <= idle;
		apb(1'h1, ADDR_EDGE_SELECT, {16'h0, sel});
		apb(1'h1, ADDR_IRQ_ENABLE, {24'h0, en});
		repeat (12) @(posedge sys_clk_i);
		apb(1'h1, ADDR_IRQ_FLAGS, 32'h0);
		apb(1'h1, ADDR_CONTROL, 32'h9);
		repeat (3) @(posedge sys_clk_i);
		chk("gated", 1, clocks_gated_o);
		chk("osc_off", 0, osc_pll_en_o);
		want <= wake;
		rst_req <= (pin < 0);
		for (int i = 0; i < 60 && exec_next_o !== 1'h1; i++) begin
			@(posedge sys_clk_i);
			dis_n += wake_delay_discharge_o;
		end
		rst_req <= 1'h0;
		chk("exec", 1, exec_next_o);
		chk("osc_on", 1, osc_pll_en_o);
		chk("settle", 3, dis_n);
		@(posedge sys_clk_i);
		chk("isr", isr, isr_call_o);
		apb(1'h0, ADDR_IRQ_FLAGS, 32'h0);
		if (pin >= 0) chk("flag", !isr, rd[pin]);
		$display("%s done", n);
	endtask
	task automatic t_regs();
		apb(1'h0, ADDR_EDGE_SELECT, 32'h0);
		chk("sel_rst", {16'h0, EDGE_SELECT_RESET}, rd);
		apb(1'h0, ADDR_WAKE_DELAY, 32'h0);
		chk("dly_rst", {16'h0, WAKE_DELAY_RESET}, rd);
		apb(1'h1, 16'hf1f0, 32'h1);
		chk("slverr", 1, err);
		apb(1'h1, ADDR_WAKE_DELAY, 32'h2);
		$display("regs done");
	endtask
	// Config off, ready missing, blocking pin, then the same pin with the event masked.
	task automatic t_refuse();
		logic [31:0] cfg [4] = '{32'h0, 32'h20, 32'h20, 32'h20};
		logic [31:0] ctl [4] = '{32'h9, 32'hb, 32'h9, 32'h9};
		apb(1'h1, ADDR_EDGE_SELECT, 32'h1);
		for (int i = 0; i < 4; i++) begin
			want <= {7'h0, i > 1};
			apb(1'h1, ADDR_EVT_ENABLE, {28'h0, i < 3, 3'h0});
			repeat (12) @(posedge sys_clk_i);
			apb(1'h1, ADDR_SYS_CONFIG, cfg[i]);
			apb(1'h1, ADDR_CONTROL, ctl[i] & 32'he);
			apb(1'h1, ADDR_CONTROL, ctl[i]);
			repeat (3) @(posedge sys_clk_i);
			chk("no_entry", 0, clocks_gated_o);
			chk("irq", i < 3, irq_o);
			apb(1'h0, ADDR_EVT_STATUS, 32'h0);
			chk("evt", 1, rd[EVT_REFUSED]);
			apb(1'h1, ADDR_EVT_CLEAR, 32'h8);
			repeat (3) @(posedge sys_clk_i);
			chk("irq_clr", 0, irq_o);
		end
		$display("refuse done");
	endtask
	task automatic t_rise();
		sleep_wake("rise", 16'h0001, 8'h00, 8'h00, 8'h01, 0, 1'h0);
	endtask
	task automatic t_fall();
		sleep_wake("fall", 16'h0800, 8'h20, 8'h20, 8'h00, 5, 1'h1);
	endtask
	task automatic t_any();
		sleep_wake("any", 16'h3000, 8'h40, 8'h42, 8'h02, 6, 1'h1);
	endtask
	task automatic t_rst();
		sleep_wake("reset", 16'h0000, 8'h00, 8'h00, 8'h00, -1, 1'h0);
	endtask
	initial begin
		repeat (12) @(posedge sys_clk_i);
		arst_n_i <= 1'h1;
		t_regs();
		t_refuse();
		t_rise();
		t_fall();
		t_any();
		t_rst();
		end_sim();
	end
endmodule
`default_nettype wire
